// [design/switch_link_pkg.sv]
// Purpose: shared constants for the octal switch serial link and fault logic
// Assumes: ref_clk at 25 MHz on both ends
// Notes: command and status bits are 1 for OFF, 0 for ON
package switch_link_pkg;
  localparam int unsigned NUM_OUT = 8;
  localparam int unsigned REF_PERIOD_NS = 40;
  // open-load filter after each write, least figure, rounded up
  localparam int unsigned FILTER_TIME_US = 25;
  localparam int unsigned FILTER_CYC = (FILTER_TIME_US * 1000 + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  // host spacing between transfers, must exceed this
  localparam int unsigned GAP_TIME_US = 100;
  localparam int unsigned GAP_CYC = (GAP_TIME_US * 1000) / REF_PERIOD_NS + 1;
  // host serial clock half period in ref_clk cycles (2.5 MHz)
  localparam int unsigned HALF_CYC = 5;
  localparam logic [7:0] ALL_OFF = 8'hff;
  localparam logic [7:0] RESET_CMD = 8'hff;
  localparam logic [3:0] BIT_LAST = 4'h7;
  typedef logic [NUM_OUT-1:0] word_t;
  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_SETUP = 6'h02,
    H_HIGH = 6'h04,
    H_LOW = 6'h08,
    H_HOLD = 6'h10,
    H_GAP = 6'h20
  } host_state_t;
endpackage : switch_link_pkg

// [design/switch_link_if.sv]
// Purpose: serial link between host and octal switch
// Assumes: host drives select, clock and data in; device drives data out
// Notes: data out is pulled high while the device leaves it undriven
`timescale 1ns/1ps
interface switch_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;
  assign so_line = so_oe ? so : 1'b1;
  modport dev (input cs_n, input sclk, input si, output so, output so_oe);
  modport host (output cs_n, output sclk, output si, input so_line);
endinterface : switch_link_if

// [design/switch_device.sv]
// Purpose: serial control and fault reporting of an eight output low-side switch
// Assumes: link logic runs on the serial clock; fault and output logic on ref_clk
// Notes: the select edges are seen on ref_clk, so the host must wait a few ref_clk
//   cycles after select falls before the first clock and after it rises before the next frame
`timescale 1ns/1ps
module switch_device (
  switch_link_if.dev link, // serial link, device end
  input wire logic ref_clk, // 25 MHz core clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire switch_link_pkg::word_t ot_fault, // per output over-temperature, async
  input wire logic load_supply_pin, // load supply over-voltage, async
  input wire switch_link_pkg::word_t drain_high, // per output drain above threshold, async
  output switch_link_pkg::word_t out_off // per output switch off, 1 = OFF
);
  import switch_link_pkg::*;

  word_t si_sh_reg;
  logic [7:0] so_sh_reg;
  logic so_started_reg;
  logic link_rst_n;
  word_t status_hold_reg;
  logic [1:0] cs_sync_reg;
  logic cs_d_reg;
  word_t ot_meta_reg;
  word_t ot_sync_reg;
  word_t dr_meta_reg;
  word_t dr_sync_reg;
  logic [1:0] ov_sync_reg;
  word_t cmd_reg;
  word_t ot_latch_reg;
  logic ov_latch_reg;
  logic ov_report_reg;
  logic [15:0] filt_cnt_reg;
  word_t out_off_reg;
  word_t status_next;
  logic cs_fall;
  logic cs_rise;
  logic filt_done;

  // link side: output shifter cleared while deselected and input shifter gated by select, so stray clocks do nothing
  assign link_rst_n = arst_n & ~link.cs_n;

  always_ff @(negedge link.sclk or negedge arst_n)
  begin
    if (!arst_n)
      si_sh_reg <= RESET_CMD;
    else if (!link.cs_n)
      si_sh_reg <= {si_sh_reg[NUM_OUT-2:0], link.si};
  end

  // the first rising edge presents bit seven, later ones shift
  always_ff @(posedge link.sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      so_sh_reg <= 8'h00;
      so_started_reg <= 1'b0;
    end
    else if (!so_started_reg)
    begin
      so_sh_reg <= status_hold_reg;
      so_started_reg <= 1'b1;
    end
    else
      so_sh_reg <= {so_sh_reg[6:0], 1'b0};
  end

  assign link.so = so_sh_reg[7];
  assign link.so_oe = ~link.cs_n;

  // core side synchronisers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cs_sync_reg <= 2'h3;
      cs_d_reg <= 1'b1;
      ot_meta_reg <= 8'h00;
      ot_sync_reg <= 8'h00;
      dr_meta_reg <= 8'hff;
      dr_sync_reg <= 8'hff;
      ov_sync_reg <= 2'h0;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[0], link.cs_n};
      cs_d_reg <= cs_sync_reg[1];
      ot_meta_reg <= ot_fault;
      ot_sync_reg <= ot_meta_reg;
      dr_meta_reg <= drain_high;
      dr_sync_reg <= dr_meta_reg;
      ov_sync_reg <= {ov_sync_reg[0], load_supply_pin};
    end
  end

  assign cs_fall = cs_d_reg & ~cs_sync_reg[1];
  assign cs_rise = ~cs_d_reg & cs_sync_reg[1];
  assign filt_done = (filt_cnt_reg == 16'h0000);

  // shifter is quiet while select is high, so the word is stable here
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cmd_reg <= RESET_CMD;
    else if (cs_rise)
      cmd_reg <= si_sh_reg;
  end

  generate
    for (genvar i = 0; i < NUM_OUT; i++)
    begin : g_out
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          ot_latch_reg[i] <= 1'b0;
        else if (ot_sync_reg[i])
          ot_latch_reg[i] <= 1'b1;
        else if (cs_rise)
          ot_latch_reg[i] <= 1'b0;
      end

      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          out_off_reg[i] <= 1'b1;
        else
          out_off_reg[i] <= cmd_reg[i] | ot_latch_reg[i] | ov_latch_reg;
      end

      // shared comparator: high drain while ON is a short, low drain while OFF is open load
      always_comb
      begin
        if (ov_report_reg)
          status_next[i] = 1'b1;
        else if (out_off_reg[i] && !filt_done)
          status_next[i] = 1'b1;
        else
          status_next[i] = dr_sync_reg[i];
      end
    end
  endgenerate

  assign out_off = out_off_reg;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ov_latch_reg <= 1'b0;
    else if (ov_sync_reg[1])
      ov_latch_reg <= 1'b1;
    else if (cs_rise)
      ov_latch_reg <= 1'b0;
  end

  // held until select next rises, at the end of the frame in progress or else of the next one
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ov_report_reg <= 1'b0;
    else if (ov_sync_reg[1])
      ov_report_reg <= 1'b1;
    else if (cs_rise)
      ov_report_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      filt_cnt_reg <= 16'h0000;
    else if (cs_rise)
      filt_cnt_reg <= 16'(FILTER_CYC);
    else if (!filt_done)
      filt_cnt_reg <= filt_cnt_reg - 16'h0001;
  end

  // status snapshot frozen while selected; the link side reads it only inside a frame
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      status_hold_reg <= ALL_OFF;
    else if (cs_sync_reg[1] && !cs_fall)
      status_hold_reg <= status_next;
  end
endmodule : switch_device

// [design/switch_host.sv]
// Purpose: host end of the octal switch serial link
// Assumes: ref_clk at 25 MHz; serial clock made by dividing it
// Notes: one word per start; next start accepted only after the spacing gap
`timescale 1ns/1ps
module switch_host (
  switch_link_if.host link, // serial link, host end
  input wire logic ref_clk, // 25 MHz clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic start, // pulse: send cmd
  input wire switch_link_pkg::word_t cmd, // command word, 1 = OFF
  output logic busy, // transfer or gap in progress
  output logic done, // pulse: status valid
  output switch_link_pkg::word_t status, // received status word
  output switch_link_pkg::word_t fault // status xor previous command
);
  import switch_link_pkg::*;

  host_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [3:0] bit_reg;
  word_t tx_reg;
  word_t rx_reg;
  word_t prev_cmd_reg;
  word_t sent_reg;
  logic [1:0] so_sync_reg;
  logic cs_n_reg;
  logic sclk_reg;
  logic si_reg;
  logic busy_reg;
  logic done_reg;
  word_t status_reg;
  word_t fault_reg;
  logic cnt_zero;

  assign cnt_zero = (cnt_reg == 16'h0000);
  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.si = si_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign status = status_reg;
  assign fault = fault_reg;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      so_sync_reg <= 2'h3;
    else
      so_sync_reg <= {so_sync_reg[0], link.so_line};
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= H_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 4'h0;
      tx_reg <= RESET_CMD;
      rx_reg <= 8'h00;
      prev_cmd_reg <= RESET_CMD;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      si_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      status_reg <= 8'h00;
      fault_reg <= 8'h00;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        H_IDLE:
        begin
          if (start)
          begin
            tx_reg <= cmd;
            si_reg <= cmd[7];
            cs_n_reg <= 1'b0;
            busy_reg <= 1'b1;
            bit_reg <= 4'h0;
            cnt_reg <= 16'(HALF_CYC - 1);
            state_reg <= H_SETUP;
          end
        end
        H_SETUP:
        begin
          if (cnt_zero)
          begin
            sclk_reg <= 1'b1;
            cnt_reg <= 16'(HALF_CYC - 1);
            state_reg <= H_HIGH;
          end
          else
            cnt_reg <= cnt_reg - 16'h0001;
        end
        H_HIGH:
        begin
          if (cnt_zero)
          begin
            // sample on the falling edge; the device changed it a half period ago
            sclk_reg <= 1'b0;
            rx_reg <= {rx_reg[6:0], so_sync_reg[1]};
            cnt_reg <= 16'(HALF_CYC - 1);
            state_reg <= (bit_reg == BIT_LAST) ? H_HOLD : H_LOW;
          end
          else
            cnt_reg <= cnt_reg - 16'h0001;
        end
        H_LOW:
        begin
          if (cnt_zero)
          begin
            sclk_reg <= 1'b1;
            si_reg <= tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b1};
            bit_reg <= bit_reg + 4'h1;
            cnt_reg <= 16'(HALF_CYC - 1);
            state_reg <= H_HIGH;
          end
          else
            cnt_reg <= cnt_reg - 16'h0001;
        end
        H_HOLD:
        begin
          if (cnt_zero)
          begin
            cs_n_reg <= 1'b1;
            status_reg <= rx_reg;
            fault_reg <= rx_reg ^ prev_cmd_reg;
            prev_cmd_reg <= sent_reg;
            done_reg <= 1'b1;
            cnt_reg <= 16'(GAP_CYC - 1);
            state_reg <= H_GAP;
          end
          else
            cnt_reg <= cnt_reg - 16'h0001;
        end
        H_GAP:
        begin
          if (cnt_zero)
          begin
            busy_reg <= 1'b0;
            state_reg <= H_IDLE;
          end
          else
            cnt_reg <= cnt_reg - 16'h0001;
        end
        default:
        begin
          state_reg <= H_IDLE;
          cs_n_reg <= 1'b1;
          sclk_reg <= 1'b0;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // the sent word has been shifted out of tx_reg; keep a copy instead
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      sent_reg <= RESET_CMD;
    else if (state_reg == H_IDLE && start)
      sent_reg <= cmd;
  end
endmodule : switch_host

// [dv/switch_link_sva.sv]
// Purpose: protocol checks on the host to switch serial link
// Assumes: link signals sampled on ref_clk; serial clock is a divided ref_clk
// Notes: helper counters give clock rises per frame and the idle gap
`timescale 1ns/1ps
module switch_link_sva (
  input wire logic ref_clk, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic cs_n, // select
  input wire logic sclk, // serial clock
  input wire logic si, // command data
  input wire logic so, // device data out
  input wire logic so_oe, // device drive enable
  input wire logic so_line // resolved data out
);
  import switch_link_pkg::*;
  logic sclk_reg;
  logic [3:0] rise_reg;
  logic [11:0] gap_reg;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      sclk_reg <= 1'b0;
    else
      sclk_reg <= sclk;
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rise_reg <= 4'h0;
    else if (cs_n)
      rise_reg <= 4'h0;
    else if (sclk && !sclk_reg)
      rise_reg <= rise_reg + 4'h1;
  end
  // saturates so the first frame after reset is not flagged
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      gap_reg <= 12'hfff;
    else if (!cs_n)
      gap_reg <= 12'h000;
    else if (gap_reg != 12'hfff)
      gap_reg <= gap_reg + 12'h001;
  end
  a_oe_follows_sel: assert property (so_oe == !cs_n)
    else $error("data out enable differs from select");
  a_idle_released: assert property (cs_n |-> so_line && !so)
    else $error("data out wire driven or shifter live while deselected");
  a_so_holds_steady: assert property (!cs_n && !$past(cs_n, 5) && $stable(sclk) |-> $stable(so))
    else $error("data out changed without a clock rise");
  a_si_held_high: assert property (sclk && $past(sclk) |-> $stable(si))
    else $error("command data moved while clock high");
  a_sclk_low_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  a_quiet_after_sel: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("clock too soon after select");
  a_eight_bits: assert property ($rose(cs_n) |-> rise_reg == 4'h8)
    else $error("frame without eight clock rises");
  a_half_period: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
    else $error("serial clock high time wrong");
  a_frame_length: assert property ($fell(cs_n) |-> ##[80:90] $rose(cs_n))
    else $error("frame length out of range");
  a_transfer_gap: assert property ($fell(cs_n) |-> gap_reg > 12'h9c4)
    else $error("transfers spaced too closely");
  c_frame: cover property ($rose(cs_n));
  c_low_bit: cover property (!cs_n && !so_line);
  c_spaced: cover property ($fell(cs_n) && gap_reg != 12'hfff);
endmodule : switch_link_sva

// [dv/tb.sv]
// Purpose: self-checking bench for host and switch ends of the serial link
// Assumes: loads modelled as drain = out_off with open and short masks
// Notes: a second device is driven by the bench to break link rules on purpose
`timescale 1ns/1ps
module tb;
  import switch_link_pkg::*;
  logic ref_clk, lclk, arst_n, start, busy, done, ov, gate2;
  word_t cmd, status, fault, ot, open_m, short_m, out_off, out_off2, prev, so_word, si_word, s2;
  int n_errors, samples_checked;
  switch_link_if lk();
  switch_link_if lk2();
  assign lk2.sclk = lclk & gate2;
  switch_host switch_host_inst (.link(lk), .ref_clk(ref_clk), .arst_n(arst_n), .start(start), .cmd(cmd),
    .busy(busy), .done(done), .status(status), .fault(fault));
  switch_device switch_device_inst (.link(lk), .ref_clk(ref_clk), .arst_n(arst_n), .ot_fault(ot),
    .load_supply_pin(ov), .drain_high((out_off & ~open_m) | short_m), .out_off(out_off));
  switch_device switch_device_inst2 (.link(lk2), .ref_clk(ref_clk), .arst_n(arst_n), .ot_fault(8'h00),
    .load_supply_pin(1'b0), .drain_high(out_off2 & 8'hfb), .out_off(out_off2));
  switch_link_sva switch_link_sva_inst (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(lk.cs_n), .sclk(lk.sclk),
    .si(lk.si), .so(lk.so), .so_oe(lk.so_oe), .so_line(lk.so_line));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // link clock of the second device, unrelated in phase, gated by gate2 to frames and to one stray burst while deselected
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  always @(negedge lk.sclk)
  begin
    so_word <= {so_word[6:0], lk.so_line};
    si_word <= {si_word[6:0], lk.si};
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input word_t exp, input word_t got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
    for (int k = 0; k < lim && sig !== lvl; k++)
      @(negedge ref_clk);
    if (sig !== lvl)
    begin
      $display("ERROR wait expected %b seen %b", lvl, sig);
      n_errors++;
      stop_test();
    end
  endtask : wait_lvl
  task automatic xfer(input word_t c, input word_t exp);
    wait_lvl(busy, 1'b0, 4000);
    start = 1'b1;
    cmd = c;
    @(negedge ref_clk);
    start = 1'b0;
    wait_lvl(done, 1'b1, 200);
    chk("status", exp, status);
    chk("fault", exp ^ prev, fault);
    chk("so wire", exp, so_word);
    chk("si wire", c, si_word);
    prev = c;
    repeat (10) @(negedge ref_clk);
  endtask : xfer
  task automatic frame2(input word_t c);
    lk2.cs_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    @(negedge lclk);
    lk2.si <= c[7];
    gate2 <= 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge lclk);
      s2[i] = lk2.so_line;
      lk2.si <= c[(i + 7) % 8];
    end
    gate2 <= 1'b0;
    repeat (4) @(negedge ref_clk);
    lk2.cs_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask : frame2
  task automatic t_basic();
    chk("reset outputs", 8'hff, out_off);
    chk("idle wire", 8'h01, {7'h00, lk.so_line});
    xfer(8'h5a, 8'hff);
    chk("outputs", 8'h5a, out_off);
    xfer(8'ha5, 8'h5a);
    chk("outputs", 8'ha5, out_off);
    short_m = 8'h40;
    xfer(8'ha5, 8'he5);
    short_m = 8'h00;
    $display("basic and short test done");
  endtask : t_basic
  task automatic t_heat();
    ot = 8'h02;
    repeat (10) @(negedge ref_clk);
    chk("heat off", 8'ha7, out_off);
    ot = 8'h00;
    repeat (10) @(negedge ref_clk);
    chk("heat held", 8'ha7, out_off);
    xfer(8'ha5, 8'ha7);
    chk("heat back", 8'ha5, out_off);
    ov = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("volt off", 8'hff, out_off);
    ov = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk("volt held", 8'hff, out_off);
    xfer(8'h00, 8'hff);
    chk("volt back", 8'h00, out_off);
    xfer(8'h00, 8'h00);
    $display("heat and voltage test done");
  endtask : t_heat
  task automatic t_open();
    open_m = 8'h10;
    xfer(8'hff, 8'h00);
    xfer(8'hff, 8'hef);
    open_m = 8'h00;
    xfer(8'hff, 8'hff);
    @(negedge lclk);
    gate2 <= 1'b1;
    lk2.si <= 1'b0;
    repeat (8) @(negedge lclk);
    gate2 <= 1'b0;
    chk("idle oe", 8'h00, {7'h00, lk2.so_oe});
    frame2(8'hff);
    frame2(8'hff);
    chk("filtered", 8'hff, s2);
    repeat (700) @(negedge ref_clk);
    frame2(8'hff);
    chk("open bit", 8'hfb, s2);
    $display("open load test done");
  endtask : t_open
  initial
  begin
    arst_n = 1'b0;
    {start, ov, gate2} = 3'h0;
    {cmd, prev} = 16'hffff;
    {ot, open_m, short_m} = 24'h000000;
    lk2.cs_n = 1'b1;
    lk2.si = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_basic();
    t_heat();
    t_open();
    stop_test();
  end
endmodule : tb
